// file: byte_array_mem.sv
// Byte-wide storage array with registered read data
`timescale 1ns/100ps
`default_nettype none
module byte_array_mem #(
  parameter int AW = 18
) (
  input  wire logic          clk,    // System clock
  input  wire logic          we,     // Write strobe
  input  wire logic [AW-1:0] addr,   // Shared read and write address
  input  wire logic [7:0]    wData,  // Write data
  output var  logic [7:0]    rData   // Read data, one clock after address
);

  logic [7:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wData;
    end
    rData <= mem[addr];
  end

endmodule
`default_nettype wire

// file: spi_fram_pkg.sv
// Constants shared by the serial byte-memory slave and its testbench
//
// Operation
// - Inputs captured on rising serial clock; output data changes on falling edge.
// - Any serial clock rate up to 25 MHz; stopped clock loses no state.
// - Chip select high: standby, other inputs ignored, serial output tristated.
// - Chip select low enables acting on serial clock edges.
// - Serial input sampled only at rising serial clock edges.
// - Serial output driven only for read data; tristated otherwise and during pause.
// - Guard enable set and write guard pin low: status writes rejected.
// - Pause low suspends operation; clock and select transitions ignored.
// - Each byte stored once fully received; no write polling needed.
// - Read-only identification gives maker, density and revision.
// - Software protects upper quarter, upper half or whole array.
// - Write disable command blocks memory writes until re-enabled.
// - Modes 0 and 3; data clocked from first rise after select.
// - First byte is opcode, then address and data; select ends command.
// - Three address bytes taken; only low 18 bits used.
package spi_fram_pkg;

  // ==========================================================================
  // Array geometry and timing
  localparam int ADDR_BITS   = 18;
  localparam int ADDR_BYTES  = 3;
  localparam int CLK_HZ      = 200_000_000;
  localparam int SCK_MAX_HZ  = 25_000_000;
  // Shortest serial clock half period in system clocks, rounded down
  localparam int SCK_HALF_CYC = CLK_HZ / (2 * SCK_MAX_HZ);
  localparam int SYNC_STAGES = 3;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_RDID  = 8'h9F;

  // ==========================================================================
  // Status byte layout and reset values
  localparam int STAT_GUARD_POS = 7;
  localparam int STAT_BP_LSB    = 2;
  localparam int STAT_WEL_POS   = 1;
  localparam logic       GUARD_RST = 1'b0;
  localparam logic [1:0] BP_RST    = 2'h0;

  // Block protect codes
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;

  localparam int ID_BYTES = 3;

endpackage

// file: spi_fram_slave.sv
// Serial-clock slave front end of the byte memory, oversampled by clk
`timescale 1ns/100ps
`default_nettype none
module spi_fram_slave
  import spi_fram_pkg::*;
#(
  parameter int         AW         = ADDR_BITS,
  parameter logic [7:0] ID_MAKER   = 8'h5A,  // Arbitrary value
  parameter logic [7:0] ID_DENSITY = 8'h22,  // Arbitrary value
  parameter logic [7:0] ID_REV     = 8'h01   // Arbitrary value
) (
  input  wire logic clk,     // 200 MHz system clock
  input  wire logic rst_b,   // Synchronous reset, active low
  input  wire logic sck,     // Serial clock pin
  input  wire logic csB,     // Chip select pin, active low
  input  wire logic si,      // Serial data in
  input  wire logic holdB,   // Pause pin, active low
  input  wire logic wpB,     // Write guard pin, active low
  output var  logic soOut,   // Serial data out value
  output var  logic soOe     // Serial data out enable
);

  // ==========================================================================
  // State
  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_OPC   = 8'b0000_0010,
    ST_ADDR  = 8'b0000_0100,
    ST_WDATA = 8'b0000_1000,
    ST_RDATA = 8'b0001_0000,
    ST_RSTAT = 8'b0010_0000,
    ST_WSTAT = 8'b0100_0000,
    ST_RID   = 8'b1000_0000
  } fsm_t;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sckSync;
    logic [SYNC_STAGES-1:0] csSync;
    logic [SYNC_STAGES-1:0] siSync;
    logic [SYNC_STAGES-1:0] holdSync;
    logic [SYNC_STAGES-1:0] wpSync;
    logic                   sckF;
    logic                   csF;
    logic                   holdF;
    logic                   wpF;
    fsm_t                   fsm;
    logic [2:0]             bitCnt;
    logic [1:0]             byteCnt;
    logic [7:0]             rxShift;
    logic                   isRead;
    logic                   wrOp;
    logic [AW-1:0]          addr;
    logic [7:0]             txShift;
    logic                   so;
    logic                   wel;
    logic                   guardEn;
    logic [1:0]             bp;
    logic [1:0]             idIdx;
  } st_t;

  st_t        q_q;
  st_t        q_d;
  logic       memWe;
  logic [7:0] memWData;
  logic [7:0] memRData;

  // ==========================================================================
  // Helpers
  function automatic logic isProtected(input logic [AW-1:0] a, input logic [1:0] bp);
    if (bp == BP_NONE) begin
      return 1'b0;
    end else if (bp == BP_QUARTER) begin
      return a[AW-1] & a[AW-2];
    end else if (bp == BP_HALF) begin
      return a[AW-1];
    end else begin
      return 1'b1;
    end
  endfunction

  function automatic logic readPhase(input fsm_t f);
    return f == ST_RDATA || f == ST_RSTAT || f == ST_RID;
  endfunction

  // Stage two and three agree: the level is trusted
  function automatic logic settled(input logic [SYNC_STAGES-1:0] s);
    return s[1] == s[2];
  endfunction

  function automatic logic [7:0] idByte(input logic [1:0] i);
    if (i == 2'h0) begin
      return ID_MAKER;
    end else if (i == 2'h1) begin
      return ID_DENSITY;
    end else begin
      return ID_REV;
    end
  endfunction

  // ==========================================================================
  // Edge detection
  logic       sckRise;
  logic       sckFall;
  logic       active;
  logic       selFall;
  logic       selRise;
  logic       byteDone;
  logic [7:0] rxByte;
  logic [7:0] statByte;

  always_comb begin
    // clock and select ignored during pause
    active  = !q_q.csF && q_q.holdF;
    sckRise = active && settled(q_q.sckSync) && q_q.sckSync[2] && !q_q.sckF;
    sckFall = active && settled(q_q.sckSync) && !q_q.sckSync[2] && q_q.sckF;
    selFall = q_q.holdF && settled(q_q.csSync) && !q_q.csSync[2] && q_q.csF;
    selRise = q_q.holdF && settled(q_q.csSync) && q_q.csSync[2] && !q_q.csF;
    // data bit taken from the same delayed sample as the clock
    rxByte   = {q_q.rxShift[6:0], q_q.siSync[2]};
    byteDone = sckRise && (q_q.bitCnt == 3'h7);
    statByte = 8'h00;
    statByte[STAT_GUARD_POS] = q_q.guardEn;
    statByte[STAT_BP_LSB+:2] = q_q.bp;
    statByte[STAT_WEL_POS]   = q_q.wel;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    q_d      = q_q;
    memWe    = 1'b0;
    memWData = rxByte;
    // oversampling keeps state through any clock stop
    q_d.sckSync  = {q_q.sckSync[1:0], sck};
    q_d.csSync   = {q_q.csSync[1:0], csB};
    q_d.siSync   = {q_q.siSync[1:0], si};
    q_d.holdSync = {q_q.holdSync[1:0], holdB};
    q_d.wpSync   = {q_q.wpSync[1:0], wpB};
    if (settled(q_q.sckSync)) begin
      q_d.sckF = q_q.sckSync[2];
    end
    if (settled(q_q.holdSync)) begin
      q_d.holdF = q_q.holdSync[2];
    end
    if (settled(q_q.wpSync)) begin
      q_d.wpF = q_q.wpSync[2];
    end
    // Select change seen during pause is taken up on release
    if (settled(q_q.csSync) && q_q.holdF) begin
      q_d.csF = q_q.csSync[2];
    end

    // new selection always starts with an opcode
    if (selFall) begin
      q_d.fsm     = ST_OPC;
      q_d.bitCnt  = 3'h0;
      q_d.byteCnt = 2'h0;
    end else if (selRise) begin
      q_d.fsm = ST_IDLE;
      if (q_q.wrOp) begin
        q_d.wel = 1'b0;
      end
      q_d.wrOp = 1'b0;
    end else if (sckRise) begin
      // input bits captured on rising edge
      q_d.rxShift = rxByte;
      q_d.bitCnt  = q_q.bitCnt + 3'h1;
    end

    if (byteDone) begin
      case (q_q.fsm)
        ST_OPC: begin
          q_d.fsm = ST_IDLE;
          if (rxByte == OP_WREN) begin
            q_d.wel = 1'b1;
          end else if (rxByte == OP_WRDI) begin
            // write disable clears the enable latch
            q_d.wel = 1'b0;
          end else if (rxByte == OP_RDSR) begin
            q_d.fsm = ST_RSTAT;
          end else if (rxByte == OP_WRSR) begin
            q_d.fsm  = ST_WSTAT;
            q_d.wrOp = 1'b1;
          end else if (rxByte == OP_READ || rxByte == OP_WRITE) begin
            q_d.fsm    = ST_ADDR;
            q_d.isRead = (rxByte == OP_READ);
            q_d.wrOp   = (rxByte == OP_WRITE);
          end else if (rxByte == OP_RDID) begin
            q_d.fsm   = ST_RID;
            q_d.idIdx = 2'h0;
          end
        end
        ST_ADDR: begin
          // upper address bits fall off the top
          q_d.addr    = {q_q.addr[AW-9:0], rxByte};
          q_d.byteCnt = q_q.byteCnt + 2'h1;
          if (q_q.byteCnt == 2'(ADDR_BYTES - 1)) begin
            q_d.fsm = q_q.isRead ? ST_RDATA : ST_WDATA;
          end
        end
        ST_WDATA: begin
          // byte stored the moment its last bit arrives
          // protected range and cleared latch block the store
          memWe    = q_q.wel && !isProtected(q_q.addr, q_q.bp);
          q_d.addr = q_q.addr + AW'(1);
        end
        ST_RDATA: begin
          q_d.addr = q_q.addr + AW'(1);
        end
        ST_WSTAT: begin
          q_d.fsm = ST_IDLE;
          // guard pin low with guard enabled rejects the write
          if (q_q.wel && !(q_q.guardEn && !q_q.wpF)) begin
            q_d.guardEn = rxByte[STAT_GUARD_POS];
            q_d.bp      = rxByte[STAT_BP_LSB+:2];
          end
        end
        ST_RID: begin
          q_d.idIdx = (q_q.idIdx == 2'(ID_BYTES - 1)) ? 2'h0 : q_q.idIdx + 2'h1;
        end
        default: begin
        end
      endcase
    end

    // output bits change on falling edge only
    if (sckFall && readPhase(q_q.fsm)) begin
      if (q_q.bitCnt == 3'h0) begin
        if (q_q.fsm == ST_RDATA) begin
          q_d.txShift = memRData;
        end else if (q_q.fsm == ST_RSTAT) begin
          q_d.txShift = statByte;
        end else begin
          q_d.txShift = idByte(q_q.idIdx);
        end
      end else begin
        q_d.txShift = {q_q.txShift[6:0], 1'b0};
      end
      q_d.so = q_d.txShift[7];
    end

    if (!rst_b) begin
      q_d         = '0;
      q_d.sckSync = '0;
      q_d.csSync  = '1;
      q_d.holdSync = '1;
      q_d.wpSync  = '1;
      q_d.csF     = 1'b1;
      q_d.holdF   = 1'b1;
      q_d.wpF     = 1'b1;
      q_d.fsm     = ST_IDLE;
      q_d.guardEn = GUARD_RST;
      q_d.bp      = BP_RST;
      memWe       = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    q_q <= q_d;
  end

  // ==========================================================================
  // Outputs and storage
  // drive only while returning read data and not paused
  assign soOe  = active && readPhase(q_q.fsm);
  assign soOut = q_q.so;

  // Array read runs every clock so data waits ahead of the next falling edge
  byte_array_mem #(.AW(AW)) u_mem (
    .clk   (clk),
    .we    (memWe),
    .addr  (q_q.addr),
    .wData (memWData),
    .rData (memRData)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_standby_quiet: assert property (q_q.holdF && q_q.csSync[2] && q_q.csSync[1] |=> !soOe)
    else $error("Output enabled while deselected");
  chk_pause_quiet: assert property (!q_q.holdSync[2] && !q_q.holdSync[1] |=> !soOe)
    else $error("Output enabled during pause");
  chk_out_on_fall: assert property ($changed(q_q.so) |-> $past(sckFall))
    else $error("Output changed off a falling edge");
  chk_sample_rise: assert property ($changed(q_q.rxShift) |-> $past(sckRise))
    else $error("Input shifted off a rising edge");
  chk_pause_freeze: assert property (!q_q.holdF |=> $stable(q_q.bitCnt) && $stable(q_q.fsm))
    else $error("Position moved during pause");
  chk_guard_reject: assert property (byteDone && q_q.fsm == ST_WSTAT && q_q.guardEn && !q_q.wpF
      |=> $stable(q_q.bp) && $stable(q_q.guardEn))
    else $error("Guarded status write took effect");
  chk_wrdi_clears: assert property (byteDone && q_q.fsm == ST_OPC && rxByte == OP_WRDI
      |=> !q_q.wel)
    else $error("Write disable left latch set");
  chk_store_now: assert property (byteDone && q_q.fsm == ST_WDATA && q_q.wel
      && !isProtected(q_q.addr, q_q.bp) |-> memWe ##1 q_q.addr == $past(q_q.addr) + AW'(1))
    else $error("Received byte not stored at once");
  chk_protect_block: assert property (memWe |-> q_q.wel && !isProtected(q_q.addr, q_q.bp))
    else $error("Store into protected range");
  chk_select_opcode: assert property (selFall |=> q_q.fsm == ST_OPC && q_q.bitCnt == 3'h0)
    else $error("Selection did not start an opcode");

endmodule
`default_nettype wire

// file: spi_fram_slave_interface_tb_top.sv
// Self-checking bench for the serial byte-memory slave
`timescale 1ns/100ps
`default_nettype none
module spi_fram_slave_interface_tb_top;
  import spi_fram_pkg::*;
  // Arbitrary identification values
  localparam logic [7:0] IDS [3] = '{8'hC3, 8'h4D, 8'h07};
  localparam logic [23:0] BND [4] = '{24'h0, 24'h030000, 24'h020000, 24'h000000};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  wire logic sck, csB, si, holdB, wpB, soOut, soOe;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] rb;
  logic [23:0] a2;

  always #2.5 clk = ~clk;

  spi_fram_slave #(.ID_MAKER(IDS[0]), .ID_DENSITY(IDS[1]), .ID_REV(IDS[2])) i_spi_fram_slave (
    .clk(clk), .rst_b(rst_b), .sck(sck), .csB(csB), .si(si), .holdB(holdB),
    .wpB(wpB), .soOut(soOut), .soOe(soOe));
  spi_master_model i_spi_master_model (
    .clk(clk), .sck(sck), .csB(csB), .si(si), .holdB(holdB),
    .wpB(wpB), .soOut(soOut), .soOe(soOe));

  // ==========================================================================
  // Checking and reporting
  task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp1(input logic exp, input logic got);
    cmp8({7'h0, exp}, {7'h0, got});
  endtask

  task automatic test_end(input string name);
    $display("Test %s done, mismatches so far %0d", name, num_errors);
  endtask

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Frames
  task automatic op2(input logic [7:0] op, input logic [7:0] tx, output logic [7:0] rx);
    i_spi_master_model.select(1'b0);
    i_spi_master_model.xfer(op, 8, rx);
    if (op != OP_WREN && op != OP_WRDI) i_spi_master_model.xfer(tx, 8, rx);
    i_spi_master_model.deselect();
  endtask

  task automatic mem(input logic [7:0] op, input logic [23:0] a, input logic [7:0] tx,
                     input int pauseAt, input logic mode3, output logic [7:0] rx);
    i_spi_master_model.select(mode3);
    i_spi_master_model.xfer(op, 8, rx);
    for (int k = 2; k >= 0; k--) i_spi_master_model.xfer(a[8*k+:8], 8, rx);
    i_spi_master_model.xfer(tx, pauseAt, rx);
    i_spi_master_model.deselect();
  endtask

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    logic [7:0] x;
    op2(OP_WREN, 8'h00, x);
    mem(OP_WRITE, a, d, 8, 1'b0, x);
  endtask

  task automatic rd(input logic [23:0] a, input logic [7:0] exp);
    logic [7:0] x;
    mem(OP_READ, a, 8'h00, 8, 1'b0, x);
    cmp8(exp, x);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    cmp1(1'b0, soOe);
    test_end("standby");
    wr(24'h000123, 8'hA5);
    rd(24'h000123, 8'hA5);
    mem(OP_READ, 24'hFC0123, 8'h00, 8, 1'b1, rb);
    cmp8(8'hA5, rb);
    cmp1(1'b0, soOe);
    test_end("write_read");
    i_spi_master_model.select(1'b0);
    i_spi_master_model.xfer(OP_RDID, 8, rb);
    for (int k = 0; k < 6; k++) begin
      i_spi_master_model.xfer(8'h00, 8, rb);
      cmp8(IDS[k % 3], rb);
    end
    i_spi_master_model.deselect();
    test_end("ident");
    wr(24'h000040, 8'h77);
    op2(OP_WREN, 8'h00, rb);
    op2(OP_WRDI, 8'h00, rb);
    mem(OP_WRITE, 24'h000040, 8'h11, 8, 1'b0, rb);
    rd(24'h000040, 8'h77);
    test_end("write_disable");
    op2(OP_WREN, 8'h00, rb);
    mem(OP_WRITE, 24'h000124, 8'hC6, 5, 1'b0, rb);
    mem(OP_READ, 24'h000124, 8'h00, 2, 1'b0, rb);
    cmp8(8'hC6, rb);
    cmp1(1'b0, i_spi_master_model.oeInPause);
    test_end("pause");
    op2(OP_WREN, 8'h00, rb);
    op2(OP_WRSR, 8'h80, rb);
    op2(OP_RDSR, 8'h00, rb);
    cmp8(8'h80, rb & 8'h8C);
    i_spi_master_model.set_wp(1'b0);
    op2(OP_WREN, 8'h00, rb);
    op2(OP_WRSR, 8'h0C, rb);
    op2(OP_RDSR, 8'h00, rb);
    cmp8(8'h80, rb & 8'h8C);
    i_spi_master_model.set_wp(1'b1);
    op2(OP_WREN, 8'h00, rb);
    op2(OP_WRSR, 8'h00, rb);
    op2(OP_RDSR, 8'h00, rb);
    cmp8(8'h00, rb & 8'h8C);
    test_end("guard");
    for (int b = 1; b <= 3; b++) begin
      a2 = (BND[b] - 24'h1) & 24'h03FFFF;
      wr(BND[b], 8'h11);
      wr(a2, 8'h11);
      op2(OP_WREN, 8'h00, rb);
      op2(OP_WRSR, {4'h0, b[1:0], 2'h0}, rb);
      wr(BND[b], 8'hEE);
      wr(a2, 8'hEE);
      rd(BND[b], 8'h11);
      rd(a2, (b == 3) ? 8'h11 : 8'hEE);
      op2(OP_WREN, 8'h00, rb);
      op2(OP_WRSR, 8'h00, rb);
    end
    test_end("protect");
    final_report();
  end
endmodule
`default_nettype wire

// file: spi_master_model.sv
// Behavioural SPI bus master that drives the memory slave pins
`timescale 1ns/100ps
`default_nettype none
module spi_master_model #(
  parameter int HALF = 24  // Serial clock half period in ns, free of clk
) (
  input  wire logic clk,    // System clock
  output var  logic sck,    // Serial clock
  output var  logic csB,    // Chip select, active low
  output var  logic si,     // Serial data to slave
  output var  logic holdB,  // Pause, active low
  output var  logic wpB,    // Write guard, active low
  input  wire logic soOut,  // Slave data value
  input  wire logic soOe    // Slave data enable
);
  logic idle;
  logic lastSo;
  logic miso;
  logic oeInPause;

  // Released line shows the inverse of its last value, never a stale match
  assign miso = soOe ? soOut : ~lastSo;
  always @(posedge clk) begin
    if (soOe) lastSo <= soOut;
  end

  initial begin
    idle = 1'b0;
    lastSo = 1'b0;
    oeInPause = 1'b1;
    sck = 1'b0;
    csB = 1'b1;
    si = 1'b0;
    holdB = 1'b1;
    wpB = 1'b1;
  end

  // ==========================================================================
  // Pin sequences
  // Pin timing runs on its own delays: the link clock is not tied to clk
  task automatic set_wp(input logic v);
    wpB <= v;
    #(HALF);
  endtask

  // fresh select fall ahead of every opcode
  task automatic select(input logic mode3);
    idle = mode3;
    sck <= mode3;
    #(HALF);
    csB <= 1'b0;
    #(HALF);
  endtask

  task automatic deselect();
    sck <= idle;
    #(HALF);
    csB <= 1'b1;
    si <= ~si;
    #(2 * HALF);
  endtask

  // pause moves only with serial clock low
  task automatic pause();
    holdB <= 1'b0;
    #(2 * HALF);
    oeInPause = soOe;
    repeat (3) begin
      sck <= 1'b1;
      #(HALF);
      sck <= 1'b0;
      #(HALF);
    end
    holdB <= 1'b1;
    #(2 * HALF);
  endtask

  // fall then rise, data held across the rise
  task automatic xfer(input logic [7:0] tx, input int pauseAt, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      #(HALF);
      if (i == pauseAt) pause();
      // Sampled just before the rise, as a master latches its input
      rx[i] = miso;
      sck <= 1'b1;
      #(HALF);
    end
  endtask
endmodule
`default_nettype wire
